// [rtl/sct_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module sct_ctrl (
	input  wire logic                        CLK,
	input  wire logic                        SYS_RST,
	sct_if.ctl                               bus,
	input  wire logic                        REQ,
	input  wire logic                        REQ_WE,
	input  wire logic [sct_pkg::BA_W-1:0]    REQ_BA,
	input  wire logic [sct_pkg::ROW_W-1:0]   REQ_ROW,
	input  wire logic [sct_pkg::COL_W-1:0]   REQ_COL,
	input  wire logic [sct_pkg::DQ_W-1:0]    REQ_WDATA,
	input  wire logic                        SLEEP,
	output logic                             READY,
	output logic [sct_pkg::DQ_W-1:0]         RDATA,
	output logic                             RVALID,
	output logic                             INIT_DONE
);

	typedef enum logic [2:0] {S_INIT, S_WAIT, S_REF, S_LMR, S_IDLE, S_RW, S_RDW, S_SREF}
		sct_st_type;

	typedef struct packed {
		sct_st_type                  st;
		sct_st_type                  ret;
		logic [9:0]                  cnt;
		logic [1:0]                  nref;
		logic [7:0]                  refc;
		logic                        inited;
		logic                        cke;
		logic [3:0]                  pins;
		logic [sct_pkg::BA_W-1:0]    ba;
		logic [sct_pkg::ADDR_W-1:0]  addr;
		logic [sct_pkg::COL_W-1:0]   col;
		logic                        we;
		logic [sct_pkg::DQ_W-1:0]    wdata;
		logic [sct_pkg::DQ_W-1:0]    dq;
		logic                        doe;
		logic                        ready;
		logic [sct_pkg::DQ_W-1:0]    rdata;
		logic                        rvalid;
	} sct_ctl_type;

	sct_ctl_type q;
	sct_ctl_type d;

	// Waiting always passes through S_WAIT, so two clocks is the least spacing.
	function automatic logic [9:0] gap(input int k);
		return 10'((k > 2) ? k - 2 : 0);
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		d        = q;
		d.pins   = sct_pkg::PIN_NOP;
		d.doe    = 1'b0;
		d.rvalid = 1'b0;
		if (q.refc != 8'hFF) begin
			d.refc = q.refc + 8'h1;
		end
		case (q.st)
			S_INIT: begin
				if (q.cnt == 10'h0) begin // see RULE14
					d.pins                   = sct_pkg::PIN_PRE;
					d.addr[sct_pkg::AP_BIT]  = 1'b1;
					d.nref                   = 2'h2;
					d.cnt                    = gap(sct_pkg::RP_CYC);
					d.ret                    = S_REF;
					d.st                     = S_WAIT;
				end else begin
					d.cnt = q.cnt - 10'h1;
				end
			end
			S_WAIT: begin
				if (q.cnt == 10'h0) begin
					d.st = q.ret;
				end else begin
					d.cnt = q.cnt - 10'h1;
				end
			end
			S_REF: begin
				d.pins = sct_pkg::PIN_REF;
				d.refc = 8'h0;
				d.nref = q.nref - 2'h1;
				d.cnt  = gap(sct_pkg::RFC_CYC);
				d.ret  = (q.nref != 2'h1) ? S_REF : (q.inited ? S_IDLE : S_LMR);
				d.st   = S_WAIT;
			end
			S_LMR: begin
				d.pins   = sct_pkg::PIN_LMR;
				d.addr   = '0;
				d.addr[sct_pkg::MR_CL_LSB +: 2] = sct_pkg::CL_CTL;
				d.addr[sct_pkg::MR_BL_LSB +: 3] = sct_pkg::BL_CTL;
				d.inited = 1'b1;
				d.cnt    = gap(sct_pkg::MRD_CYC); // see RULE11
				d.ret    = S_IDLE;
				d.st     = S_WAIT;
			end
			S_IDLE: begin
				if (REQ && q.ready) begin
					d.pins  = sct_pkg::PIN_ACT; // see RULE20
					d.ba    = REQ_BA;
					d.addr  = REQ_ROW;
					d.col   = REQ_COL;
					d.we    = REQ_WE;
					d.wdata = REQ_WDATA;
					d.cnt   = gap(sct_pkg::RCD_CYC);
					d.ret   = S_RW;
					d.st    = S_WAIT;
				end else if (SLEEP) begin
					d.pins = sct_pkg::PIN_REF;
					d.cke  = 1'b0;
					d.st   = S_SREF;
				end else if (q.refc >= 8'(sct_pkg::REFI_CYC)) begin
					// A missed interval gets the two wake-up refreshes again.
					d.nref = (q.refc >= 8'(2 * sct_pkg::REFI_CYC)) ? 2'h2 : 2'h1; // see RULE15
					d.st   = S_REF;
				end
			end
			S_RW: begin
				d.pins                  = q.we ? sct_pkg::PIN_WR : sct_pkg::PIN_RD;
				d.addr                  = '0;
				d.addr[sct_pkg::COL_W-1:0] = q.col; // see RULE21
				d.addr[sct_pkg::AP_BIT] = 1'b1;
				if (q.we) begin
					d.dq  = q.wdata; // see RULE10
					d.doe = 1'b1;
					// Covers recovery plus precharge and any later column command.
					d.cnt = gap(sct_pkg::WR2ACT_CYC); // see RULE6 see RULE7 see RULE3 see RULE2
					d.ret = S_IDLE;
					d.st  = S_WAIT;
				end else begin
					d.cnt = 10'(sct_pkg::CL_CTL);
					d.st  = S_RDW;
				end
			end
			S_RDW: begin
				if (q.cnt == 10'h0) begin
					d.rdata  = bus.dq;
					d.rvalid = 1'b1;
					d.cnt    = gap(sct_pkg::RP_CYC);
					d.ret    = S_IDLE;
					d.st     = S_WAIT;
				end else begin
					d.cnt = q.cnt - 10'h1;
				end
			end
			S_SREF: begin
				d.refc = 8'h0;
				if (!SLEEP) begin
					d.cke = 1'b1;
					d.cnt = gap(sct_pkg::XSR_CYC); // see RULE13
					d.ret = S_IDLE;
					d.st  = S_WAIT;
				end
			end
			default: d.st = S_IDLE;
		endcase
		d.ready = (d.st == S_IDLE) && !SLEEP;
	end

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			q     <= '0;
			q.st  <= S_INIT;
			q.cnt <= 10'(sct_pkg::INIT_CYC);
			q.cke <= 1'b1;
			q.pins <= sct_pkg::PIN_NOP;
		end else begin
			q <= d; // see RULE16
		end
	end

	assign bus.cke     = q.cke;
	assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = q.pins;
	assign bus.ba      = q.ba;
	assign bus.addr    = q.addr;
	assign bus.dqm     = 1'b0;
	assign bus.dq_c    = q.dq;
	assign bus.dq_oe_c = q.doe;
	assign READY       = q.ready;
	assign RDATA       = q.rdata;
	assign RVALID      = q.rvalid;
	assign INIT_DONE   = q.inited;

endmodule // sct_ctrl
`default_nettype wire

// [rtl/sct_device.sv]
// Summary of operation
// RULE1 - Column commands accepted on every clock.
// RULE2 - Burst stop one clock after write data.
// RULE3 - New column command one clock after data.
// RULE4 - CKE low suspends from next clock.
// RULE5 - CKE high resumes from next clock.
// RULE6 - Write data to ACTIVE: five clocks.
// RULE7 - Write data to PRECHARGE: two clocks.
// RULE8 - Write mask acts with zero latency.
// RULE9 - Read mask floats outputs two clocks later.
// RULE10 - First write data with WRITE command.
// RULE11 - Mode load to ACTIVE/refresh: two clocks.
// RULE12 - Precharge floats read outputs after CAS latency.
// RULE13 - Self refresh exit wait before ACTIVE.
// RULE14 - Power-up pause then two refreshes.
// RULE15 - Repeat two refreshes when interval missed.
// RULE16 - Clock stays constant during accesses.
// RULE17 - All inputs sampled on rising edge.
// RULE18 - Four banks, 8192 rows, 512 columns.
// RULE19 - Accesses are bursts of programmed length, order.
// RULE20 - ACTIVE latches bank and row.
// RULE21 - Column taken from A[8:0].
// RULE22 - Auto precharge starts after write recovery.
// RULE23 - Decode strobes into commands.
// RULE24 - A10 selects automatic precharge.
`timescale 1ns/1ps
`default_nettype none
module sct_device (
	input  wire logic                   CLK,
	input  wire logic                   SYS_RST,
	sct_if.dev                          bus,
	output logic                        SUSPENDED,
	output logic                        SELF_REFRESH,
	output logic [sct_pkg::NBANK-1:0]   BANK_OPEN
);

	////////////////////////////////////////////////////////////////////////////////

	typedef struct packed {
		logic                                        susp;
		logic                                        sref;
		logic [1:0]                                  cl;
		logic [2:0]                                  blc;
		logic                                        bt;
		logic [sct_pkg::NBANK-1:0]                   open;
		logic [sct_pkg::NBANK-1:0][sct_pkg::ROW_W-1:0] row;
		logic                                        bact;
		logic                                        bwr;
		logic                                        bap;
		logic [sct_pkg::BA_W-1:0]                    bbank;
		logic [sct_pkg::COL_W-1:0]                   bcol;
		logic [2:0]                                  bcnt;
		logic [1:0]                                  apc;
		logic [sct_pkg::BA_W-1:0]                    apbank;
		logic [1:0][sct_pkg::DQ_W:0]                 pipe;
		logic                                        dqm;
		logic [sct_pkg::DQ_W-1:0]                    dout;
		logic                                        doe;
	} sct_dev_type;

	sct_dev_type                     q;
	sct_dev_type                     d;
	logic [3:0]                      pins;
	logic                            beat;
	logic                            rd_beat;
	logic                            b_wr;
	logic                            b_ap;
	logic [sct_pkg::BA_W-1:0]        b_bank;
	logic [sct_pkg::COL_W-1:0]       b_col;
	logic [2:0]                      b_cnt;
	logic [2:0]                      mask;
	logic [2:0]                      off;
	logic [sct_pkg::COL_W-1:0]       col;
	logic [sct_pkg::MEM_AW-1:0]      mem_idx;
	logic                            mem_we;
	logic [sct_pkg::DQ_W-1:0]        mem_rd;
	logic [sct_pkg::DQ_W:0]          src;

	// Only a slice of each bank's rows is stored; the full row number is still
	// tracked per bank so that row handling matches the real array.
	logic [sct_pkg::DQ_W-1:0]        mem [0:(1<<sct_pkg::MEM_AW)-1];

	assign mem_rd = mem[mem_idx];

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		d       = q;
		pins    = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
		beat    = 1'b0;
		b_wr    = q.bwr;
		b_ap    = q.bap;
		b_bank  = q.bbank;
		b_col   = q.bcol;
		b_cnt   = q.bcnt;
		mask    = sct_pkg::len_mask(q.blc);
		mem_we  = 1'b0;
		src     = q.pipe[1];
		// A low CKE freezes the next edge; a high one frees it.
		d.susp  = ~bus.cke; // see RULE4 see RULE5
		if (bus.cke) begin
			d.sref = 1'b0;
		end
		if (!q.susp) begin
			d.dqm = bus.dqm; // see RULE17
			if (q.apc != 2'h0) begin
				d.apc = q.apc - 2'h1;
				if (q.apc == 2'h1) begin
					d.open[q.apbank] = 1'b0; // see RULE22
				end
			end
			beat = q.bact;
			case (pins) // see RULE23
				sct_pkg::PIN_ACT: begin
					d.open[bus.ba] = 1'b1; // see RULE20
					d.row[bus.ba]  = bus.addr;
				end
				sct_pkg::PIN_RD, sct_pkg::PIN_WR: begin
					// A new column command cuts off any burst in flight.
					beat   = 1'b1; // see RULE1 see RULE10
					b_wr   = ~bus.we_n;
					b_bank = bus.ba;
					b_col  = bus.addr[sct_pkg::COL_W-1:0]; // see RULE21
					b_cnt  = 3'h0;
					b_ap   = bus.addr[sct_pkg::AP_BIT]; // see RULE24
				end
				sct_pkg::PIN_BST: begin
					beat   = 1'b0;
					d.bact = 1'b0;
				end
				sct_pkg::PIN_PRE: begin
					if (bus.addr[sct_pkg::AP_BIT]) begin
						d.open = '0;
					end else begin
						d.open[bus.ba] = 1'b0;
					end
					if (bus.addr[sct_pkg::AP_BIT] || bus.ba == q.bbank) begin
						beat   = 1'b0; // see RULE12
						d.bact = 1'b0;
					end
				end
				sct_pkg::PIN_REF: begin
					if (!bus.cke) begin
						d.sref = 1'b1;
					end
				end
				sct_pkg::PIN_LMR: begin
					d.cl  = bus.addr[sct_pkg::MR_CL_LSB +: 2];
					d.blc = bus.addr[sct_pkg::MR_BL_LSB +: 3];
					d.bt  = bus.addr[sct_pkg::MR_BT_BIT];
				end
				default: begin
				end
			endcase
		end
		// Burst order wraps inside the aligned block of the burst length.
		off     = q.bt ? (b_col[2:0] ^ b_cnt) : (b_col[2:0] + b_cnt); // see RULE19
		col     = {b_col[sct_pkg::COL_W-1:3], (b_col[2:0] & ~mask) | (off & mask)};
		mem_idx = {b_bank, q.row[b_bank][sct_pkg::MEM_ROW_BITS-1:0], col}; // see RULE18
		rd_beat = beat & ~b_wr;
		if (!q.susp) begin
			mem_we = beat & b_wr & ~bus.dqm; // see RULE8
			if (beat) begin
				d.bwr   = b_wr;
				d.bap   = b_ap;
				d.bbank = b_bank;
				d.bcol  = b_col;
				d.bcnt  = b_cnt + 3'h1;
				d.bact  = (b_cnt != mask);
				if (b_cnt == mask && b_ap) begin
					if (b_wr) begin
						d.apc    = 2'(sct_pkg::AP_WR_CYC); // see RULE22
						d.apbank = b_bank;
					end else begin
						d.open[b_bank] = 1'b0;
					end
				end
			end
			d.pipe[1] = q.pipe[0];
			d.pipe[0] = {rd_beat, mem_rd};
			// The tap sets the read latency; draining the pipe after a precharge
			// is what floats the pins exactly one latency later.
			case (q.cl)
				2'h1: src = {rd_beat, mem_rd};
				2'h2: src = q.pipe[0];
				default: src = q.pipe[1];
			endcase
			d.dout = src[sct_pkg::DQ_W-1:0];
			d.doe  = src[sct_pkg::DQ_W] & ~q.dqm; // see RULE9 see RULE12
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			q    <= '0;
			q.cl <= sct_pkg::CL_RST;
		end else begin
			q <= d;
		end
	end

	always_ff @(posedge CLK) begin
		if (mem_we) begin
			mem[mem_idx] <= bus.dq;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign bus.dq_d    = q.dout;
	assign bus.dq_oe_d = q.doe;
	assign SUSPENDED    = q.susp;
	assign SELF_REFRESH = q.sref;
	assign BANK_OPEN    = q.open;

endmodule // sct_device
`default_nettype wire

// [rtl/sct_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface sct_if;
	logic                        cke;
	logic                        cs_n;
	logic                        ras_n;
	logic                        cas_n;
	logic                        we_n;
	logic                        dqm;
	logic [sct_pkg::BA_W-1:0]    ba;
	logic [sct_pkg::ADDR_W-1:0]  addr;
	logic [sct_pkg::DQ_W-1:0]    dq_c;
	logic                        dq_oe_c;
	logic [sct_pkg::DQ_W-1:0]    dq_d;
	logic                        dq_oe_d;
	wire  [sct_pkg::DQ_W-1:0]    dq;

	// An undriven bus shows the inverse of the device's last word, so a late sample reads wrong.
	assign dq = dq_oe_c ? dq_c : (dq_oe_d ? dq_d : ~dq_d);

	modport dev (
		input  cke, cs_n, ras_n, cas_n, we_n, dqm, ba, addr, dq,
		output dq_d, dq_oe_d
	);
	modport ctl (
		output cke, cs_n, ras_n, cas_n, we_n, dqm, ba, addr, dq_c, dq_oe_c,
		input  dq
	);
endinterface
`default_nettype wire

// [rtl/sct_pkg.sv]
`default_nettype none
package sct_pkg;
	localparam int CLK_MHZ      = 10;
	localparam int DQ_W         = 16;
	localparam int ROW_W        = 13;
	localparam int COL_W        = 9;
	localparam int BA_W         = 2;
	localparam int NBANK        = 4;
	localparam int ADDR_W       = 13;
	localparam int AP_BIT       = 10;
	localparam int MR_BL_LSB    = 0;
	localparam int MR_BT_BIT    = 3;
	localparam int MR_CL_LSB    = 4;
	localparam int MEM_ROW_BITS = 3;
	localparam int MEM_AW       = BA_W + MEM_ROW_BITS + COL_W;

	localparam int T_INIT_US  = 100;
	localparam int T_XSR_NS   = 75;
	localparam int T_REF_MS   = 64;
	localparam int REF_ROWS   = 8192;
	localparam int T_RCD_NS   = 20;
	localparam int T_RP_NS    = 20;
	localparam int T_RFC_NS   = 66;
	localparam int T_WR_PS    = 7500;
	localparam int MRD_CYC    = 2;
	localparam int WR2PRE_CYC = 2;
	localparam int WR2ACT_CYC = 5;
	localparam int XSR_TOGGLE = 2;

	function automatic int ns2cyc(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		return (c < 1) ? 1 : c;
	endfunction

	localparam int INIT_CYC  = T_INIT_US * CLK_MHZ;
	localparam int XSR_CYC   = (ns2cyc(T_XSR_NS) < XSR_TOGGLE) ? XSR_TOGGLE : ns2cyc(T_XSR_NS);
	// Rounded down, so the spread refreshes finish a little inside the period.
	localparam int REFI_CYC  = (T_REF_MS * 1000 * CLK_MHZ) / REF_ROWS;
	localparam int AP_WR_CYC = 1 + (T_WR_PS * CLK_MHZ + 999999) / 1000000;
	localparam int RCD_CYC   = ns2cyc(T_RCD_NS);
	localparam int RP_CYC    = ns2cyc(T_RP_NS);
	localparam int RFC_CYC   = ns2cyc(T_RFC_NS);

	localparam logic [1:0] CL_RST   = 2'h2;
	localparam logic [1:0] CL_CTL   = 2'h2;
	localparam logic [2:0] BL_CTL   = 3'h0;

	// Command pins in the order chip select, row strobe, column strobe, write enable.
	localparam logic [3:0] PIN_NOP = 4'h7;
	localparam logic [3:0] PIN_ACT = 4'h3;
	localparam logic [3:0] PIN_RD  = 4'h5;
	localparam logic [3:0] PIN_WR  = 4'h4;
	localparam logic [3:0] PIN_BST = 4'h6;
	localparam logic [3:0] PIN_PRE = 4'h2;
	localparam logic [3:0] PIN_REF = 4'h1;
	localparam logic [3:0] PIN_LMR = 4'h0;

	function automatic logic [2:0] len_mask(input logic [2:0] code);
		case (code)
			3'h0: return 3'h0;
			3'h1: return 3'h1;
			3'h2: return 3'h3;
			default: return 3'h7;
		endcase
	endfunction
endpackage
`default_nettype wire

// [verif/sct_chk.sv]
`timescale 1ns/1ps
`default_nettype none
module sct_chk (
	input  wire logic                       CLK,
	input  wire logic                       SYS_RST,
	input  wire logic                       cke,
	input  wire logic                       cs_n,
	input  wire logic                       ras_n,
	input  wire logic                       cas_n,
	input  wire logic                       we_n,
	input  wire logic                       dqm,
	input  wire logic [sct_pkg::BA_W-1:0]   ba,
	input  wire logic [sct_pkg::ADDR_W-1:0] addr,
	input  wire logic                       dq_oe_c,
	input  wire logic                       dq_oe_d
);
	logic [3:0]  cmd;
	logic        act;
	logic        rd;
	logic        wr;
	logic        lmr;
	logic        aref;
	logic        pre;
	logic [10:0] init_q;
	logic [1:0]  refs_q;

	////////////////////////////////////////////////////////////////////////////
	assign cmd  = {cs_n, ras_n, cas_n, we_n};
	assign act  = cke && (cmd == sct_pkg::PIN_ACT);
	assign rd   = cke && (cmd == sct_pkg::PIN_RD);
	assign wr   = cke && (cmd == sct_pkg::PIN_WR);
	assign lmr  = cke && (cmd == sct_pkg::PIN_LMR);
	assign aref = cke && (cmd == sct_pkg::PIN_REF);
	assign pre  = cke && (cmd == sct_pkg::PIN_PRE);

	// Counting from reset release lets one check stand for the whole power-up pause.
	always_ff @(posedge CLK) begin
		if (SYS_RST) begin
			init_q <= 11'h000;
			refs_q <= 2'h0;
		end else begin
			if (init_q != 11'h7FF)
				init_q <= init_q + 11'h001;
			if (aref && refs_q != 2'h3)
				refs_q <= refs_q + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);

	a_init_pause: assert property ((act || aref) |-> init_q >= sct_pkg::INIT_CYC)
		else $error("command issued inside the power-up pause");
	a_two_refresh: assert property (act |-> refs_q >= 2'h2)
		else $error("row opened before two refreshes");
	a_col_after_act: assert property ((rd || wr) |-> $past(act, 2) && ba == $past(ba, 2))
		else $error("column command without open row in its bank");
	a_wdata_with_wr: assert property (wr == dq_oe_c)
		else $error("write data not with write command");
	a_read_beat: assert property (rd && !dqm |-> ##2 dq_oe_d ##1 !dq_oe_d)
		else $error("read beat not one clock at latency two");
	a_read_cause: assert property (dq_oe_d |-> $past(rd, 2) && !$past(dqm, 2))
		else $error("device drove data without a read");
	a_bus_clash: assert property (!(dq_oe_c && dq_oe_d))
		else $error("both ends drive data");
	a_mrd_gap: assert property (lmr |=> !(act || aref))
		else $error("mode load followed too soon");
	a_wr_pre_gap: assert property (wr |=> !pre)
		else $error("precharge too soon after write data");
	a_wr_act_gap: assert property (wr |=> (!act) [*4])
		else $error("row opened too soon after write data");
	a_exit_wait: assert property ($rose(cke) |-> !act ##1 !act)
		else $error("row opened too soon after clock enable");

	c_read: cover property (rd ##2 dq_oe_d);
	c_wr_rd: cover property (wr ##[1:20] rd);
	c_sleep: cover property ($fell(cke));
	c_wake: cover property ($rose(cke));
endmodule // sct_chk
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                         CLK;
	logic                         SYS_RST;
	logic                         REQ;
	logic                         REQ_WE;
	logic                         SLEEP;
	logic                         READY;
	logic                         RVALID;
	logic                         INIT_DONE;
	logic                         SUSPENDED;
	logic                         SELF_REFRESH;
	logic [sct_pkg::NBANK-1:0]    BANK_OPEN;
	logic [sct_pkg::BA_W-1:0]     REQ_BA;
	logic [sct_pkg::ROW_W-1:0]    REQ_ROW;
	logic [sct_pkg::COL_W-1:0]    REQ_COL;
	logic [sct_pkg::DQ_W-1:0]     REQ_WDATA;
	logic [sct_pkg::DQ_W-1:0]     RDATA;
	logic [sct_pkg::DQ_W-1:0]     mem_m [logic [13:0]];
	logic [sct_pkg::DQ_W-1:0]     exp_q [$];
	logic [23:0]                  keys [$];
	logic [31:0]                  rnd;
	int                           err_total;
	int                           tests_run;
	int                           seed;
	int                           i;
	int                           n;

	sct_if bus ();
	sct_device u_sct_device (.CLK(CLK), .SYS_RST(SYS_RST), .bus(bus), .SUSPENDED(SUSPENDED),
		.SELF_REFRESH(SELF_REFRESH), .BANK_OPEN(BANK_OPEN));
	sct_ctrl u_sct_ctrl (.CLK(CLK), .SYS_RST(SYS_RST), .bus(bus), .REQ(REQ), .REQ_WE(REQ_WE),
		.REQ_BA(REQ_BA), .REQ_ROW(REQ_ROW), .REQ_COL(REQ_COL), .REQ_WDATA(REQ_WDATA),
		.SLEEP(SLEEP), .READY(READY), .RDATA(RDATA), .RVALID(RVALID), .INIT_DONE(INIT_DONE));
	sct_chk u_sct_chk (.CLK(CLK), .SYS_RST(SYS_RST), .cke(bus.cke), .cs_n(bus.cs_n),
		.ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .dqm(bus.dqm), .ba(bus.ba),
		.addr(bus.addr), .dq_oe_c(bus.dq_oe_c), .dq_oe_d(bus.dq_oe_d));

	////////////////////////////////////////////////////////////////////////////
	initial begin
		CLK = 1'b0;
		forever #50 CLK = ~CLK;
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp || $isunknown(seen)) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic tick_or_quit(input int lim);
		@(posedge CLK);
		#1;
		n++;
		if (n > lim) begin
			err_total++;
			report_and_stop();
		end
	endtask

	// READY is registered, so its value just after an edge is what the next edge samples.
	task automatic wait_ready;
		n = 0;
		while (READY !== 1'b1)
			tick_or_quit(3000);
	endtask

	task automatic do_req(input logic we, input logic [23:0] k, input logic [15:0] d);
		wait_ready();
		REQ = 1'b1;
		REQ_WE = we;
		{REQ_BA, REQ_ROW, REQ_COL} = k;
		REQ_WDATA = d;
		if (we)
			mem_m[{k[23:22], k[11:9], k[8:0]}] = d;
		else
			exp_q.push_back(mem_m[{k[23:22], k[11:9], k[8:0]}]);
		@(posedge CLK);
		#1;
		REQ = 1'b0;
	endtask

	task automatic read_back(input int lo, input int hi);
		for (int j = hi; j >= lo; j--)
			do_req(1'b0, keys[j], 16'h0000);
		n = 0;
		while (exp_q.size() != 0)
			tick_or_quit(100);
	endtask

	// A result with no note waiting is compared against its own inverse, so it always counts.
	always @(posedge CLK)
		if (RVALID === 1'b1)
			check(RDATA, (exp_q.size() != 0) ? exp_q.pop_front() : ~RDATA);

	initial begin
		#(100 * 60000);
		err_total++;
		report_and_stop();
	end

	////////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 46437;
		err_total = 0;
		tests_run = 0;
		{SYS_RST, REQ, REQ_WE, SLEEP} = 4'h8;
		{REQ_BA, REQ_ROW, REQ_COL, REQ_WDATA} = 40'h00_0000_0000;
		repeat (2) @(posedge CLK);
		#1;
		SYS_RST = 1'b0;
		check({15'h0000, INIT_DONE}, 16'h0000);
		wait_ready();
		check({15'h0000, INIT_DONE}, 16'h0001);
		$display("test power_up done");
		for (i = 0; i < 24; i++) begin
			rnd = $random(seed);
			// Keys 0 to 7 share row zero, so only the column keeps bank neighbours apart.
			keys.push_back({i[1:0], (i < 8) ? 13'h0000 : rnd[12:0],
				(i < 4) ? 9'h000 : (i < 8) ? 9'h1FF : rnd[24:16]});
			rnd = $random(seed);
			do_req(1'b1, keys[i], rnd[15:0]);
		end
		read_back(0, 23);
		wait_ready();
		check({12'h000, BANK_OPEN}, 16'h0000);
		$display("test write_read done");
		repeat (400) @(posedge CLK);
		#1;
		read_back(0, 7);
		$display("test refresh_idle done");
		SLEEP = 1'b1;
		n = 0;
		while (SELF_REFRESH !== 1'b1)
			tick_or_quit(200);
		repeat (50) @(posedge CLK);
		#1;
		check({15'h0000, SUSPENDED}, 16'h0001);
		SLEEP = 1'b0;
		wait_ready();
		check({14'h0000, SUSPENDED, SELF_REFRESH}, 16'h0000);
		read_back(8, 15);
		$display("test self_refresh done");
		report_and_stop();
	end
endmodule // tb_top
`default_nettype wire
